// ===== design/gpio_input_qualifier_analog_mux.sv
// Functional notes
// - Selector field upper bit 0 gives the pin its digital I/O function.
// - Selector upper bit 1 routes pin to converter, comparator fields also to comparator; reset state.
// - Qualifier code 00 only synchronizes the pin; reset default for every pin.
// - Codes 01 and 10 synchronize, then pass the sampling-window qualifier.
// - Sampling period field in control register, one per group of 8 pins.
// - Window of 3 or 6 samples; output changes only when all agree.
// - Code 11 passes the pin with no synchronization.
// - Unrouted peripheral input sits at a fixed per-peripheral default level.
// - Data register: write loads output latch, read returns pin input.
// - Period 0 samples every cycle; n samples every 2n cycles.
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module gpio_input_qualifier_analog_mux import gpio_qual_pkg::*; #(
	parameter int NUM_PERIPH = 4,
	parameter logic [3:0] PERIPH_DEFAULT = 4'hA
) (
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic [PIN_COUNT-1:0] i_pin_in,
	output logic [PIN_COUNT-1:0] o_pin_out,
	output logic [PIN_COUNT-1:0] o_pin_oe,
	output logic [PIN_COUNT-1:0] o_pin_value,
	output logic [NUM_PERIPH-1:0] o_periph_in,
	output logic [FIELD_COUNT-1:0] o_analog_route,
	output logic [FIELD_COUNT-1:0] o_comparator_route,
	output logic [FIELD_COUNT-1:0] o_aio_digital_sel
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [31:0] analog_select;
	logic [31:0] next_analog_select;
	logic [31:0] qualifier_select;
	logic [31:0] next_qualifier_select;
	logic [15:0] qualifier_control;
	logic [15:0] next_qualifier_control;
	logic [31:0] periph_route;
	logic [31:0] next_periph_route;
	logic [PIN_COUNT-1:0] next_pin_out;
	logic [PIN_COUNT-1:0] next_pin_oe;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic [FIELD_COUNT-1:0] next_analog_route;
	logic [FIELD_COUNT-1:0] next_comparator_route;
	logic [FIELD_COUNT-1:0] next_aio_digital_sel;
	logic setup;
	logic write_access;
	logic addr_hit;

	assign setup = i_psel && !i_penable;
	assign write_access = i_psel && i_penable && o_pready && i_pwrite;

	always_comb begin
		next_analog_select = analog_select;
		next_qualifier_select = qualifier_select;
		next_qualifier_control = qualifier_control;
		next_periph_route = periph_route;
		next_pin_out = o_pin_out;
		next_pin_oe = o_pin_oe;
		next_prdata = o_prdata;
		next_pready = setup;
		addr_hit = 1'b1;
		case (i_paddr)
			ADDR_PORT_DATA: next_prdata = {16'h0000, o_pin_value};
			ADDR_PORT_DIRECTION: next_prdata = {16'h0000, o_pin_oe};
			ADDR_QUALIFIER_SELECT: next_prdata = qualifier_select;
			ADDR_QUALIFIER_CONTROL: next_prdata = {16'h0000, qualifier_control};
			ADDR_ANALOG_SELECT: next_prdata = analog_select;
			ADDR_PERIPH_ROUTE: next_prdata = periph_route;
			default: begin
				next_prdata = 32'h00000000;
				addr_hit = 1'b0;
			end
		endcase
		if (!(setup && !i_pwrite)) begin
			next_prdata = o_prdata;
		end
		next_pslverr = setup && !addr_hit;
		if (write_access) begin
			case (i_paddr)
				ADDR_PORT_DATA: next_pin_out = i_pwdata[PIN_COUNT-1:0];
				ADDR_PORT_DIRECTION: next_pin_oe = i_pwdata[PIN_COUNT-1:0];
				ADDR_QUALIFIER_SELECT: next_qualifier_select = i_pwdata;
				ADDR_QUALIFIER_CONTROL: next_qualifier_control = i_pwdata[15:0];
				ADDR_ANALOG_SELECT: next_analog_select = i_pwdata;
				ADDR_PERIPH_ROUTE: next_periph_route = i_pwdata;
				default: next_pin_out = o_pin_out;
			endcase
		end
		for (int f = 0; f < FIELD_COUNT; f++) begin
			next_analog_route[f] = next_analog_select[2 * f + FIELD_ROUTE_BIT] && ANALOG_FIELD_MASK[f];
			next_comparator_route[f] = next_analog_select[2 * f + FIELD_ROUTE_BIT] && COMPARATOR_FIELD_MASK[f];
			next_aio_digital_sel[f] = !next_analog_select[2 * f + FIELD_ROUTE_BIT] && DIGITAL_FIELD_MASK[f];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			analog_select <= ANALOG_SELECT_RESET;
			qualifier_select <= QUALIFIER_SELECT_RESET;
			qualifier_control <= QUALIFIER_CONTROL_RESET;
			periph_route <= PERIPH_ROUTE_RESET;
			o_pin_out <= PORT_RESET;
			o_pin_oe <= PORT_RESET;
			o_prdata <= 32'h00000000;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_analog_route <= ANALOG_FIELD_MASK;
			o_comparator_route <= COMPARATOR_FIELD_MASK;
			o_aio_digital_sel <= 16'h0000;
		end else begin
			analog_select <= next_analog_select;
			qualifier_select <= next_qualifier_select;
			qualifier_control <= next_qualifier_control;
			periph_route <= next_periph_route;
			o_pin_out <= next_pin_out;
			o_pin_oe <= next_pin_oe;
			o_prdata <= next_prdata;
			o_pready <= next_pready;
			o_pslverr <= next_pslverr;
			o_analog_route <= next_analog_route;
			o_comparator_route <= next_comparator_route;
			o_aio_digital_sel <= next_aio_digital_sel;
		end
	end

	// ----------------------------------------------------------------
	// Sampling clock per group
	// ----------------------------------------------------------------
	logic [COUNT_W-1:0] sample_cnt [GROUP_COUNT];
	logic [COUNT_W-1:0] next_sample_cnt [GROUP_COUNT];
	logic [GROUP_COUNT-1:0] sample_tick;

	always_comb begin
		for (int g = 0; g < GROUP_COUNT; g++) begin
			sample_tick[g] = (qualifier_control[g * PERIOD_W +: PERIOD_W] == 8'h00) ||
				(sample_cnt[g] >= COUNT_W'({qualifier_control[g * PERIOD_W +: PERIOD_W], 1'b0} - 9'h001));
			next_sample_cnt[g] = sample_tick[g] ? 9'h000 : COUNT_W'(sample_cnt[g] + 9'h001);
		end
	end

	always_ff @(posedge i_core_clk) begin
		for (int g = 0; g < GROUP_COUNT; g++) begin
			if (i_reset) begin
				sample_cnt[g] <= 9'h000;
			end else begin
				sample_cnt[g] <= next_sample_cnt[g];
			end
		end
	end

	// ----------------------------------------------------------------
	// Pin synchronizer, qualifier and mode select
	// ----------------------------------------------------------------
	logic [PIN_COUNT-1:0] sync_first;
	logic [PIN_COUNT-1:0] sync_pin;
	logic [PIN_COUNT-1:0] window_q;
	logic [PIN_COUNT-1:0] next_pin_value;

	for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
		gpio_sample_window u_window (
			.i_core_clk(i_core_clk),
			.i_reset(i_reset),
			.i_sample(sync_pin[p]),
			.i_tick(sample_tick[p / PINS_PER_GROUP]),
			.i_six(qual_mode_t'(field2(qualifier_select, p)) == QUAL_WINDOW6),
			.o_q(window_q[p])
		);
	end

	always_comb begin
		for (int p = 0; p < PIN_COUNT; p++) begin
			case (qual_mode_t'(field2(qualifier_select, p)))
				QUAL_SYNC: next_pin_value[p] = sync_pin[p];
				QUAL_WINDOW3, QUAL_WINDOW6: next_pin_value[p] = window_q[p];
				QUAL_ASYNC: next_pin_value[p] = i_pin_in[p];
				default: next_pin_value[p] = sync_pin[p];
			endcase
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			sync_first <= '0;
			sync_pin <= '0;
			o_pin_value <= '0;
		end else begin
			sync_first <= i_pin_in;
			sync_pin <= sync_first;
			o_pin_value <= next_pin_value;
		end
	end

	// ----------------------------------------------------------------
	// Peripheral input routing
	// ----------------------------------------------------------------
	logic [NUM_PERIPH-1:0] next_periph_in;

	always_comb begin
		for (int k = 0; k < NUM_PERIPH; k++) begin
			if (periph_route[k * ROUTE_W + ROUTE_ENABLE_BIT]) begin
				next_periph_in[k] = o_pin_value[periph_route[k * ROUTE_W +: ROUTE_INDEX_W]];
			end else begin
				next_periph_in[k] = PERIPH_DEFAULT[k];
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_periph_in <= NUM_PERIPH'(PERIPH_DEFAULT);
		end else begin
			o_periph_in <= next_periph_in;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	a_select_digital: assert property (!analog_select[5] |-> o_aio_digital_sel[2] && !o_analog_route[2])
		else $error("field 2 digital select not honoured");
	a_select_reset: assert property ($fell(i_reset) |-> analog_select == ANALOG_SELECT_RESET &&
		o_analog_route == ANALOG_FIELD_MASK && o_comparator_route == COMPARATOR_FIELD_MASK)
		else $error("analog selector not in analog routing after reset");
	a_qsel_reset: assert property ($fell(i_reset) |-> qualifier_select == QUALIFIER_SELECT_RESET)
		else $error("qualifier select not zero after reset");
	a_sync_delay: assert property ((field2(qualifier_select, 0) == 2'h0) [*3]
		|-> o_pin_value[0] == $past(i_pin_in[0], 3))
		else $error("synchronized pin value not three cycles behind pin");
	a_window_path: assert property ((field2(qualifier_select, 2) == 2'h1) [*2]
		|-> o_pin_value[2] == $past(window_q[2]))
		else $error("qualified mode bypassed the window");
	a_tick_every: assert property (qualifier_control[7:0] == 8'h00 |-> sample_tick[0])
		else $error("period zero did not sample every cycle");
	a_tick_spacing: assert property ((sample_tick[1] && qualifier_control[15:8] == 8'h02) ##1
		(qualifier_control[15:8] == 8'h02) [*4] |-> sample_tick[1] && !$past(sample_tick[1]) &&
		!$past(sample_tick[1], 2) && !$past(sample_tick[1], 3))
		else $error("period two did not sample every four cycles");
	a_raw_pass: assert property ((field2(qualifier_select, 1) == 2'h3) [*2]
		|-> o_pin_value[1] == $past(i_pin_in[1]))
		else $error("unsynchronized mode added delay");
	a_periph_default: assert property (!periph_route[ROUTE_ENABLE_BIT] |=> o_periph_in[0] == PERIPH_DEFAULT[0])
		else $error("unrouted peripheral input not at default");
	a_data_write: assert property (write_access && i_paddr == ADDR_PORT_DATA
		|=> o_pin_out == $past(i_pwdata[PIN_COUNT-1:0]))
		else $error("data write did not load output latch");
	a_data_read: assert property (setup && !i_pwrite && i_paddr == ADDR_PORT_DATA
		|=> o_pready && o_prdata == {16'h0000, $past(o_pin_value)})
		else $error("data read did not return pin value");
	a_unused_field: assert property (!o_analog_route[5] && !o_aio_digital_sel[5] && !o_comparator_route[5])
		else $error("unused selector field affected routing");

	c_data_write: cover property (write_access && i_paddr == ADDR_PORT_DATA);
	c_window_change: cover property (field2(qualifier_select, 3) == 2'h2 && $changed(o_pin_value[3]));
	c_raw_change: cover property (field2(qualifier_select, 1) == 2'h3 && $changed(o_pin_value[1]));
	c_unmapped: cover property (o_pslverr && o_pready);
endmodule : gpio_input_qualifier_analog_mux
`default_nettype wire

// ===== design/gpio_sample_window.sv
`timescale 1ns/10ps
`default_nettype none
module gpio_sample_window import gpio_qual_pkg::*; (
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic i_sample,
	input wire logic i_tick,
	input wire logic i_six,
	output logic o_q
);
	logic [HISTORY_DEPTH-1:0] history;
	logic [HISTORY_DEPTH-1:0] next_history;
	logic next_q;
	logic all_ones;
	logic all_zeros;

	// ----------------------------------------------------------------
	// Sample history and agreement
	// ----------------------------------------------------------------
	always_comb begin
		next_history = i_tick ? {history[HISTORY_DEPTH-2:0], i_sample} : history;
		all_ones = i_six ? &history : &history[SHORT_WINDOW-1:0];
		all_zeros = i_six ? ~|history : ~|history[SHORT_WINDOW-1:0];
		next_q = o_q;
		if (all_ones) begin
			next_q = 1'b1;
		end else if (all_zeros) begin
			next_q = 1'b0;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			history <= '0;
			o_q <= 1'b0;
		end else begin
			history <= next_history;
			o_q <= next_q;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);

	a_window_agree: assert property ($changed(o_q) |-> $past(all_ones) || $past(all_zeros))
		else $error("window output changed without agreeing samples");
	a_hold_disagree: assert property (!(all_ones || all_zeros) |=> $stable(o_q))
		else $error("window output moved while samples disagree");
endmodule : gpio_sample_window
`default_nettype wire

// ===== shared/gpio_qual_pkg.sv
`default_nettype none
package gpio_qual_pkg;
	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_PORT_DATA = 8'h00;
	localparam logic [7:0] ADDR_PORT_DIRECTION = 8'h04;
	localparam logic [7:0] ADDR_QUALIFIER_SELECT = 8'h08;
	localparam logic [7:0] ADDR_QUALIFIER_CONTROL = 8'h0C;
	localparam logic [7:0] ADDR_ANALOG_SELECT = 8'h10;
	localparam logic [7:0] ADDR_PERIPH_ROUTE = 8'h14;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] ANALOG_SELECT_RESET = 32'hAAAAAAAA;
	localparam logic [31:0] QUALIFIER_SELECT_RESET = 32'h00000000;
	localparam logic [15:0] QUALIFIER_CONTROL_RESET = 16'h0000;
	localparam logic [15:0] PORT_RESET = 16'h0000;
	localparam logic [31:0] PERIPH_ROUTE_RESET = 32'h00000000;

	// ----------------------------------------------------------------
	// Sizes and field layout
	// ----------------------------------------------------------------
	localparam int PIN_COUNT = 16;
	localparam int PINS_PER_GROUP = 8;
	localparam int GROUP_COUNT = PIN_COUNT / PINS_PER_GROUP;
	localparam int FIELD_COUNT = 16;
	localparam int PERIOD_W = 8;
	localparam int COUNT_W = PERIOD_W + 1;
	localparam int HISTORY_DEPTH = 6;
	localparam int SHORT_WINDOW = 3;
	localparam int ROUTE_W = 8;
	localparam int ROUTE_ENABLE_BIT = 7;
	localparam int ROUTE_INDEX_W = 4;
	localparam int FIELD_ROUTE_BIT = 1;

	// Selector fields that have a pin function at all
	localparam logic [15:0] ANALOG_FIELD_MASK = 16'hDEDF;
	// Selector fields whose pin also has a digital function
	localparam logic [15:0] DIGITAL_FIELD_MASK = 16'h5454;
	// Selector fields that also feed a comparator
	localparam logic [15:0] COMPARATOR_FIELD_MASK = 16'h1414;

	typedef enum logic [1:0] {
		QUAL_SYNC,
		QUAL_WINDOW3,
		QUAL_WINDOW6,
		QUAL_ASYNC
	} qual_mode_t;

	function automatic logic [1:0] field2(input logic [31:0] v, input int unsigned i);
		return v[2 * i +: 2];
	endfunction : field2
endpackage : gpio_qual_pkg
`default_nettype wire

// ===== sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb import gpio_qual_pkg::*;;
	logic core_clk;
	logic reset;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [15:0] pins;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [15:0] pin_out;
	logic [15:0] pin_oe;
	logic [15:0] pin_value;
	logic [3:0] periph_in;
	logic [15:0] analog_route;
	logic [15:0] comparator_route;
	logic [15:0] aio_digital_sel;
	int fails;
	int checks;
	int cycles;
	logic [31:0] rd;
	logic err;

	gpio_input_qualifier_analog_mux #(.NUM_PERIPH(4), .PERIPH_DEFAULT(4'hA)) DUT (
		.i_core_clk(core_clk), .i_reset(reset), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_pin_in(pins), .o_pin_out(pin_out), .o_pin_oe(pin_oe), .o_pin_value(pin_value),
		.o_periph_in(periph_in), .o_analog_route(analog_route), .o_comparator_route(comparator_route),
		.o_aio_digital_sel(aio_digital_sel)
	);

	// ----------------------------------------------------------------
	// Clock, timeout and checking
	// ----------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails = fails + 1;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : report_and_stop

	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp32

	task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
		cmp32({16'h0000, got}, {16'h0000, exp});
	endtask : cmp16

	task automatic cmp_lat(input int got, input int lo, input int hi);
		checks = checks + 1;
		if (got < lo || got > hi) begin
			fails = fails + 1;
			$display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask : cmp_lat

	// ----------------------------------------------------------------
	// APB master
	// ----------------------------------------------------------------
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1) begin
			@(posedge core_clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Let the landed write settle before callers look
		@(negedge core_clk);
	endtask : apb

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
		apb(1'b0, a, 32'h00000000);
		cmp32(rd, exp);
		cmp16({15'h0000, err}, {15'h0000, exp_err});
	endtask : rd_chk

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		cmp16(analog_route, 16'hDEDF);
		cmp16(comparator_route, 16'h1414);
		cmp16(aio_digital_sel, 16'h0000);
		cmp16({12'h000, periph_in}, 16'h000A);
		rd_chk(ADDR_ANALOG_SELECT, 32'hAAAAAAAA, 1'b0);
		rd_chk(ADDR_QUALIFIER_SELECT, 32'h00000000, 1'b0);
		rd_chk(ADDR_QUALIFIER_CONTROL, 32'h00000000, 1'b0);
		rd_chk(ADDR_PERIPH_ROUTE, 32'h00000000, 1'b0);
		rd_chk(8'h18, 32'h00000000, 1'b1);
	endtask : t_reset

	task automatic t_analog();
		apb(1'b1, ADDR_ANALOG_SELECT, 32'h08020800);
		cmp16(analog_route, 16'h0000);
		cmp16(aio_digital_sel, 16'h5454);
		cmp16(comparator_route, 16'h0000);
		rd_chk(ADDR_ANALOG_SELECT, 32'h08020800, 1'b0);
		apb(1'b1, ADDR_ANALOG_SELECT, 32'hFFFFFFFF);
		cmp16(analog_route, 16'hDEDF);
		cmp16(comparator_route, 16'h1414);
		cmp16(aio_digital_sel, 16'h0000);
	endtask : t_analog

	task automatic t_data();
		@(posedge core_clk);
		pins <= 16'hA5CB;
		apb(1'b1, ADDR_PORT_DATA, 32'h00001234);
		apb(1'b1, ADDR_PORT_DIRECTION, 32'h000000FF);
		cmp16(pin_out, 16'h1234);
		cmp16(pin_oe, 16'h00FF);
		rd_chk(ADDR_PORT_DATA, 32'h0000A5CB, 1'b0);
		apb(1'b1, ADDR_PERIPH_ROUTE, 32'h00000083);
		repeat (2) @(negedge core_clk);
		cmp16({12'h000, periph_in}, 16'h000B);
		@(posedge core_clk);
		pins <= 16'h0000;
		repeat (6) @(negedge core_clk);
		cmp16({12'h000, periph_in}, 16'h000A);
	endtask : t_data

	task automatic lat(input int p, input int lo, input int hi);
		int n;
		n = 0;
		@(posedge core_clk);
		pins[p] <= 1'b1;
		do begin
			@(negedge core_clk);
			n = n + 1;
		end while (pin_value[p] !== 1'b1 && n < 40);
		cmp_lat(n - 1, lo, hi);
		@(posedge core_clk);
		pins[p] <= 1'b0;
		repeat (30) @(negedge core_clk);
		cmp16({15'h0000, pin_value[p]}, 16'h0000);
	endtask : lat

	task automatic glitch(input int p, input int w);
		logic seen;
		seen = 1'b0;
		for (int i = 0; i < w + 14; i++) begin
			@(posedge core_clk);
			pins[p] <= (i < w);
			@(negedge core_clk);
			if (pin_value[p] === 1'b1) begin
				seen = 1'b1;
			end
		end
		cmp16({15'h0000, seen}, 16'h0000);
	endtask : glitch

	task automatic t_qual();
		apb(1'b1, ADDR_QUALIFIER_SELECT, 32'h0001009C);
		apb(1'b1, ADDR_QUALIFIER_CONTROL, 32'h00000200);
		lat(0, 3, 3);
		lat(1, 1, 1);
		lat(2, 5, 9);
		lat(3, 8, 12);
		lat(8, 10, 20);
		glitch(2, 2);
		glitch(3, 5);
		glitch(8, 5);
	endtask : t_qual

	initial begin
		fails = 0;
		checks = 0;
		cycles = 0;
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		pins = 16'h0000;
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		t_reset();
		t_analog();
		t_data();
		t_qual();
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
